// [host_port_defs.vh]
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the host port controller and its testbench
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH

`define OFS_DYNAMIC_FIFO_CONFIG 12'h05c
`define OFS_PERIODIC_TX_FIFO_SIZE 12'h100
`define OFS_IN_EP1_TX_FIFO_SIZE 12'h104
`define OFS_IN_EP2_TX_FIFO_SIZE 12'h108
`define OFS_IN_EP3_TX_FIFO_SIZE 12'h10c
`define OFS_HARDWARE_CONFIG_FOUR 12'h050
`define OFS_HOST_CONFIGURATION 12'h400
`define OFS_HOST_FRAME_INTERVAL 12'h404
`define OFS_HOST_FRAME_NUMBER 12'h408
`define OFS_PERIODIC_QUEUE_STATUS 12'h410
`define OFS_CHANNEL_INT_SUMMARY 12'h414
`define OFS_CHANNEL_INT_MASK 12'h418
`define OFS_PORT_CONTROL_STATUS 12'h440
`define OFS_PORT_EVENT_INPUTS 12'h444

`define RST_DYNAMIC_FIFO_CONFIG 32'h00000c00
`define RST_PERIODIC_TX_FIFO_SIZE 32'h02000315
`define RST_IN_EP1_TX_FIFO_SIZE 32'h01000235
`define RST_IN_EP2_TX_FIFO_SIZE 32'h01000335
`define RST_IN_EP3_TX_FIFO_SIZE 32'h02000435
`define RST_HARDWARE_CONFIG_FOUR 32'h63f0a010
`define RST_FRAME_INTERVAL 16'hea60
`define RST_FRAME_COUNT 16'h3fff
`define MAX_FRAME_COUNT 16'h3fff

`define CFG_MODE_TIMER 27
`define CFG_PER_SCHED 26
`define CFG_LIST_HI 25
`define CFG_LIST_LO 24
`define CFG_DESC_DMA 23

`define PRT_SPEED_HI 18
`define PRT_SPEED_LO 17
`define PRT_TEST_HI 16
`define PRT_TEST_LO 13
`define PRT_POWER 12
`define PRT_OC_CHANGE 5
`define PRT_OC_ACTIVE 4
`define PRT_EN_CHANGE 3
`define PRT_ENABLED 2
`define PRT_CONNECT 1
`define PRT_CONN_STATUS 0

`define FIFO_DEPTH_MIN 16'd16
`define FIFO_DEPTH_MAX 16'h8000

`define MODE_WAIT_PHY_CLOCKS 200
`define MICROFRAME_US 125

`endif

// [host_port_ctrl.v]
// Host port, frame timing and configuration registers of a dual-role
// USB controller. Assumes an APB master on pclk and a PHY clocked
// synchronously to pclk, so one pclk stands for one PHY clock.
// Queue and FIFO fill levels arrive as inputs from the transfer engine.
//
// Summary of operation
// - With timer on, wait 200 clocks after resume, then opmode 10 to 00.
// - Frame list code 00 selects 8 entries, code 01 selects 16.
// - DMA mode from bus DMA and descriptor DMA bits; 0/1 is illegal.
// - Frame interval counts PHY clocks between SOFs, resets to 60000.
// - Remaining time counts down; at one reload interval and send SOF.
// - Frame number increments per SOF, wraps after 3fff, resets 3fff.
// - Queue head shows odd frame, channel, type and last-entry bits.
// - Queue space reports free request entries, zero to eight.
// - Periodic FIFO space reports free words, zero to 200 hex.
// - Channel summary has one read-only bit per channel, resets zero.
// - Channel mask per channel, resets zero, gates host interrupt.
// - Port speed encodes high 00, full 01, low 10.
// - Nonzero test code enters test mode and drives that pattern.
// - Overcurrent-change flag sets on overcurrent toggle, write 1 clears.
// - Enable-change flag sets on port-enabled change, write 1 clears.
// - Hardware sets port enabled; software may only disable by writing 1.
// - Connect sets connect flag and port interrupt; write 1 clears.
// - Data width field reads fixed 10, read-only constant.
// - Configuration word shows debounce present on bits 24 to 20.
// - FIFO depths in words, 16 to 32768; periodic FIFO 512 at 789.
`timescale 1ns/10ps
`include "host_port_defs.vh"

module host_port_ctrl #(
    parameter CLK_MHZ = 50,
    parameter CHANNELS = 12,
    parameter QUEUE_DEPTH = 8,
    parameter FIFO_WORDS = 512
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire bus_dma_enable,
    input wire device_connect,
    input wire port_enable_grant,
    input wire port_error_disable,
    input wire overcurrent_in,
    input wire [1:0] device_speed,
    input wire resume_end,
    input wire [CHANNELS-1:0] channel_event,
    input wire [QUEUE_DEPTH*8-1:0] queue_entries,
    input wire [3:0] queue_used,
    input wire [15:0] fifo_used,
    output reg [1:0] phy_opmode,
    output reg [3:0] test_pattern,
    output reg test_mode,
    output reg port_power,
    output reg sof_pulse,
    output reg [1:0] dma_mode,
    output reg dma_mode_illegal,
    output reg [6:0] list_entries,
    output reg port_interrupt_status,
    output reg host_channel_interrupt
);

// ------------------------------------------------------------------
// Constants
// ------------------------------------------------------------------
localparam [15:0] mode_wait = `MODE_WAIT_PHY_CLOCKS;
localparam [1:0] opmode_normal = 2'h0;
localparam [1:0] opmode_no_stuff = 2'h2;
localparam [1:0] dma_slave = 2'h0;
localparam [1:0] dma_buffered = 2'h1;
localparam [1:0] dma_scatter = 2'h2;
localparam [2:0] st_idle = 3'h1;
localparam [2:0] st_wait = 3'h2;
localparam [2:0] st_done = 3'h4;

function [15:0] clamp_depth;
    input [15:0] depth;
    begin
        if (depth < `FIFO_DEPTH_MIN)
            clamp_depth = `FIFO_DEPTH_MIN;
        else if (depth > `FIFO_DEPTH_MAX)
            clamp_depth = `FIFO_DEPTH_MAX;
        else
            clamp_depth = depth;
    end
endfunction

function [31:0] fifo_word;
    input [31:0] old;
    input [31:0] wr;
    begin
        fifo_word = {clamp_depth(wr[31:16]), wr[15:0]};
    end
endfunction

// ------------------------------------------------------------------
// Register storage
// ------------------------------------------------------------------
reg [31:0] dynamic_fifo_config;
reg [31:0] periodic_tx_fifo_size;
reg [31:0] in_ep1_tx_fifo_size;
reg [31:0] in_ep2_tx_fifo_size;
reg [31:0] in_ep3_tx_fifo_size;

reg mode_change_timer_enable;
reg periodic_schedule_enable;
reg [1:0] frame_list_entries;
reg descriptor_dma_select;
reg desc_dma_locked;

reg reload_control;
reg [15:0] frame_interval;
reg interval_locked;
reg [15:0] frame_remaining;
reg [15:0] frame_count;

reg [CHANNELS-1:0] channel_interrupt_summary;
reg [CHANNELS-1:0] channel_interrupt_mask;

reg port_enabled;
reg enable_change_flag;
reg overcurrent_active;
reg overcurrent_change_flag;
reg connect_detected;
reg connect_prev;

reg [15:0] mode_timer;
reg [2:0] mode_state;

wire wr_en = psel & penable & pwrite;
wire wr1_enabled = wr_en && paddr == `OFS_PORT_CONTROL_STATUS;

wire [7:0] periodic_queue_head = queue_entries[7:0];
wire [7:0] periodic_queue_space = QUEUE_DEPTH[7:0] - {4'h0, queue_used};
wire [15:0] fifo_space = FIFO_WORDS[15:0] - fifo_used;
wire [1:0] port_speed = device_speed;

assign pready = 1'b1;
assign pslverr = 1'b0;

// ------------------------------------------------------------------
// Configuration and FIFO sizing writes
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dynamic_fifo_config <= `RST_DYNAMIC_FIFO_CONFIG;
        periodic_tx_fifo_size <= `RST_PERIODIC_TX_FIFO_SIZE;
        in_ep1_tx_fifo_size <= `RST_IN_EP1_TX_FIFO_SIZE;
        in_ep2_tx_fifo_size <= `RST_IN_EP2_TX_FIFO_SIZE;
        in_ep3_tx_fifo_size <= `RST_IN_EP3_TX_FIFO_SIZE;
        mode_change_timer_enable <= 1'b0;
        periodic_schedule_enable <= 1'b0;
        frame_list_entries <= 2'h0;
        descriptor_dma_select <= 1'b0;
        desc_dma_locked <= 1'b0;
        reload_control <= 1'b0;
        frame_interval <= `RST_FRAME_INTERVAL;
        interval_locked <= 1'b0;
        channel_interrupt_mask <= {CHANNELS{1'b0}};
        test_pattern <= 4'h0;
        port_power <= 1'b0;
    end else if (wr_en) begin
        case (paddr)
        `OFS_DYNAMIC_FIFO_CONFIG: dynamic_fifo_config <= pwdata;
        `OFS_PERIODIC_TX_FIFO_SIZE:
            periodic_tx_fifo_size <= fifo_word(periodic_tx_fifo_size, pwdata);
        `OFS_IN_EP1_TX_FIFO_SIZE:
            in_ep1_tx_fifo_size <= fifo_word(in_ep1_tx_fifo_size, pwdata);
        `OFS_IN_EP2_TX_FIFO_SIZE:
            in_ep2_tx_fifo_size <= fifo_word(in_ep2_tx_fifo_size, pwdata);
        `OFS_IN_EP3_TX_FIFO_SIZE:
            in_ep3_tx_fifo_size <= fifo_word(in_ep3_tx_fifo_size, pwdata);
        `OFS_HOST_CONFIGURATION: begin
            mode_change_timer_enable <= pwdata[`CFG_MODE_TIMER];
            periodic_schedule_enable <= pwdata[`CFG_PER_SCHED];
            frame_list_entries <= pwdata[`CFG_LIST_HI:`CFG_LIST_LO];
            // Only the first change after reset sticks
            if (!desc_dma_locked &&
                pwdata[`CFG_DESC_DMA] != descriptor_dma_select) begin
                descriptor_dma_select <= pwdata[`CFG_DESC_DMA];
                desc_dma_locked <= 1'b1;
            end
        end
        `OFS_HOST_FRAME_INTERVAL: begin
            reload_control <= pwdata[16];
            // Later writes need reload control set beforehand
            if (port_enabled && (!interval_locked || reload_control)) begin
                frame_interval <= pwdata[15:0];
                interval_locked <= 1'b1;
            end
        end
        `OFS_CHANNEL_INT_MASK:
            channel_interrupt_mask <= pwdata[CHANNELS-1:0];
        `OFS_PORT_CONTROL_STATUS: begin
            test_pattern <= pwdata[`PRT_TEST_HI:`PRT_TEST_LO];
            port_power <= pwdata[`PRT_POWER];
        end
        default: ;
        endcase
    end
end

always @* begin
    test_mode = test_pattern != 4'h0;
    case ({bus_dma_enable, descriptor_dma_select})
    2'b00: dma_mode = dma_slave;
    2'b10: dma_mode = dma_buffered;
    2'b11: dma_mode = dma_scatter;
    default: dma_mode = dma_slave;
    endcase
    dma_mode_illegal = !bus_dma_enable && descriptor_dma_select;

    case (frame_list_entries)
    2'b00: list_entries = 7'd8;
    2'b01: list_entries = 7'd16;
    2'b10: list_entries = 7'd32;
    default: list_entries = 7'd64;
    endcase

    port_interrupt_status = connect_detected | enable_change_flag |
        overcurrent_change_flag;
    host_channel_interrupt =
        |(channel_interrupt_summary & channel_interrupt_mask);
end

// ------------------------------------------------------------------
// Micro-frame timing
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        frame_remaining <= `RST_FRAME_INTERVAL;
        frame_count <= `RST_FRAME_COUNT;
        sof_pulse <= 1'b0;
    end else begin
        sof_pulse <= 1'b0;
        if (!port_enabled) begin
            frame_remaining <= frame_interval;
        end else if (frame_remaining <= 16'h1) begin
            // Reload one clock early so SOFs stand one interval apart
            frame_remaining <= frame_interval;
            sof_pulse <= 1'b1;
            if (frame_count == `MAX_FRAME_COUNT)
                frame_count <= 16'h0;
            else
                frame_count <= frame_count + 16'h1;
        end else begin
            frame_remaining <= frame_remaining - 16'h1;
        end
    end
end

// ------------------------------------------------------------------
// Resume-end opmode timer
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        mode_state <= st_idle;
        mode_timer <= 16'h0;
        phy_opmode <= opmode_normal;
    end else begin
        case (mode_state)
        st_idle:
            if (resume_end && mode_change_timer_enable) begin
                mode_state <= st_wait;
                mode_timer <= 16'h0;
                phy_opmode <= opmode_no_stuff;
            end
        st_wait:
            if (mode_timer == mode_wait - 16'h1) begin
                mode_state <= st_done;
                phy_opmode <= opmode_normal;
            end else begin
                mode_timer <= mode_timer + 16'h1;
            end
        st_done:
            mode_state <= st_idle;
        default:
            mode_state <= st_idle;
        endcase
    end
end

// ------------------------------------------------------------------
// Port status and change flags (flag set wins over clear; disable wins over grant)
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        port_enabled <= 1'b0;
        enable_change_flag <= 1'b0;
        overcurrent_active <= 1'b0;
        overcurrent_change_flag <= 1'b0;
        connect_detected <= 1'b0;
        connect_prev <= 1'b0;
        channel_interrupt_summary <= {CHANNELS{1'b0}};
    end else begin
        connect_prev <= device_connect;
        overcurrent_active <= overcurrent_in;
        channel_interrupt_summary <= channel_event;
        if (port_error_disable ||
            (wr1_enabled && pwdata[`PRT_ENABLED]))
            port_enabled <= 1'b0;
        else if (port_enable_grant)
            port_enabled <= 1'b1;
        if (port_enabled != (port_error_disable ? 1'b0 :
            (wr1_enabled && pwdata[`PRT_ENABLED]) ? 1'b0 :
            (port_enable_grant | port_enabled)))
            enable_change_flag <= 1'b1;
        else if (wr1_enabled && pwdata[`PRT_EN_CHANGE])
            enable_change_flag <= 1'b0;
        if (overcurrent_in != overcurrent_active)
            overcurrent_change_flag <= 1'b1;
        else if (wr1_enabled && pwdata[`PRT_OC_CHANGE])
            overcurrent_change_flag <= 1'b0;
        // Rising edge only, so a device held attached flags once
        if (device_connect && !connect_prev)
            connect_detected <= 1'b1;
        else if (wr1_enabled && pwdata[`PRT_CONNECT])
            connect_detected <= 1'b0;
    end
end

// ------------------------------------------------------------------
// Read data
// ------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
        // Captured in setup; stands through the access phase
        case (paddr)
        `OFS_DYNAMIC_FIFO_CONFIG: prdata <= dynamic_fifo_config;
        `OFS_PERIODIC_TX_FIFO_SIZE: prdata <= periodic_tx_fifo_size;
        `OFS_IN_EP1_TX_FIFO_SIZE: prdata <= in_ep1_tx_fifo_size;
        `OFS_IN_EP2_TX_FIFO_SIZE: prdata <= in_ep2_tx_fifo_size;
        `OFS_IN_EP3_TX_FIFO_SIZE: prdata <= in_ep3_tx_fifo_size;
        `OFS_HARDWARE_CONFIG_FOUR:
            prdata <= `RST_HARDWARE_CONFIG_FOUR;
        `OFS_HOST_CONFIGURATION:
            prdata <= {4'h0, mode_change_timer_enable,
                periodic_schedule_enable, frame_list_entries,
                descriptor_dma_select, 23'h0};
        `OFS_HOST_FRAME_INTERVAL:
            prdata <= {15'h0, reload_control, frame_interval};
        `OFS_HOST_FRAME_NUMBER: prdata <= {frame_remaining, frame_count};
        `OFS_PERIODIC_QUEUE_STATUS:
            prdata <= {periodic_queue_head, periodic_queue_space, fifo_space};
        `OFS_CHANNEL_INT_SUMMARY:
            prdata <= {{(32-CHANNELS){1'b0}}, channel_interrupt_summary};
        `OFS_CHANNEL_INT_MASK:
            prdata <= {{(32-CHANNELS){1'b0}}, channel_interrupt_mask};
        `OFS_PORT_CONTROL_STATUS:
            prdata <= {13'h0, port_speed, test_pattern, port_power, 6'h0,
                overcurrent_change_flag, overcurrent_active,
                enable_change_flag, port_enabled, connect_detected,
                device_connect};
        `OFS_PORT_EVENT_INPUTS:
            prdata <= {30'h0, port_interrupt_status, host_channel_interrupt};
        default: prdata <= 32'h0;
        endcase
    end
end

endmodule // host_port_ctrl

// [port_ctrl_properties.sv]
// Checker: pin-level timing relations of the host port controller
// Assumes binding to host_port_ctrl in one pclk domain
`timescale 1ns/10ps

module port_ctrl_checker #(
    parameter CHANNELS = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire bus_dma_enable,
    input wire device_connect,
    input wire overcurrent_in,
    input wire [CHANNELS-1:0] channel_event,
    input wire [1:0] phy_opmode,
    input wire [3:0] test_pattern,
    input wire test_mode,
    input wire sof_pulse,
    input wire [1:0] dma_mode,
    input wire dma_mode_illegal,
    input wire [6:0] list_entries,
    input wire port_interrupt_status,
    input wire host_channel_interrupt
);
    // ----
    // Helper logic and sequences
    // ----
    reg [8:0] opmode_run;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Counts cycles spent in the resume opmode, saturating
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opmode_run <= 9'h0;
        end else if (phy_opmode != 2'b10) begin
            opmode_run <= 9'h0;
        end else if (opmode_run != 9'h1ff) begin
            opmode_run <= opmode_run + 9'h1;
        end
    end

    sequence cfg_write;
        psel && penable && pwrite && paddr == 12'h400;
    endsequence
    sequence port_write;
        psel && penable && pwrite && paddr == 12'h440 && pwdata[16:13] < 4'h6;
    endsequence

    list_size_a: assert property (cfg_write |=>
        list_entries == (7'h8 << $past(pwdata[25:24])))
        else $error("list entry count wrong");
    dma_slave_a: assert property (!bus_dma_enable &&
        !dma_mode_illegal |-> dma_mode == 2'b00)
        else $error("slave mode wrong");
    dma_legal_a: assert property (bus_dma_enable |->
        !dma_mode_illegal && dma_mode != 2'b00) else $error("dma mode wrong");
    test_code_a: assert property (port_write |=>
        test_pattern == $past(pwdata[16:13]) &&
        test_mode == ($past(pwdata[16:13]) != 4'h0))
        else $error("test pattern wrong");
    opmode_wait_a: assert property (phy_opmode != 2'b10 &&
        opmode_run != 9'h0 |-> opmode_run == 9'd200)
        else $error("opmode hold wrong");
    sof_single_a: assert property (sof_pulse |=> !sof_pulse [*8])
        else $error("sof pulse too long");
    connect_flag_a: assert property ($rose(device_connect) |->
        ##[1:3] port_interrupt_status) else $error("connect not flagged");
    overcurrent_flag_a: assert property ($changed(overcurrent_in) |->
        ##[1:3] port_interrupt_status) else $error("overcurrent not flagged");
    chan_quiet_a: assert property (channel_event == 0 |=>
        !host_channel_interrupt) else $error("channel interrupt spurious");
endmodule // port_ctrl_checker

bind host_port_ctrl port_ctrl_checker #(.CHANNELS(CHANNELS))
    i_port_ctrl_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .bus_dma_enable(bus_dma_enable), .device_connect(device_connect),
    .overcurrent_in(overcurrent_in), .channel_event(channel_event),
    .phy_opmode(phy_opmode), .test_pattern(test_pattern),
    .test_mode(test_mode), .sof_pulse(sof_pulse), .dma_mode(dma_mode),
    .dma_mode_illegal(dma_mode_illegal), .list_entries(list_entries),
    .port_interrupt_status(port_interrupt_status),
    .host_channel_interrupt(host_channel_interrupt));

// [usb_device_model.sv]
// Port-side model: PHY and attached device, commanded by bench tasks
// Assumes its tasks are called right after a pclk edge
`timescale 1ns/10ps

module usb_device_model (
    input wire pclk,
    output logic device_connect,
    output logic port_enable_grant,
    output logic port_error_disable,
    output logic overcurrent_in,
    output logic [1:0] device_speed,
    output logic resume_end
);
    initial begin
        device_connect = 1'b0;
        port_enable_grant = 1'b0;
        port_error_disable = 1'b0;
        overcurrent_in = 1'b0;
        device_speed = 2'b00;
        resume_end = 1'b0;
    end
    task attach(input logic [1:0] spd);
        @(posedge pclk);
        device_speed <= spd;
        device_connect <= 1'b1;
    endtask
    task pulse_grant;
        @(posedge pclk);
        port_enable_grant <= 1'b1;
        @(posedge pclk);
        port_enable_grant <= 1'b0;
    endtask
    task pulse_error;
        @(posedge pclk);
        port_error_disable <= 1'b1;
        @(posedge pclk);
        port_error_disable <= 1'b0;
    endtask
    task pulse_resume;
        @(posedge pclk);
        resume_end <= 1'b1;
        @(posedge pclk);
        resume_end <= 1'b0;
    endtask
    task set_overcurrent(input logic v);
        @(posedge pclk);
        overcurrent_in <= v;
    endtask
endmodule // usb_device_model

// [test_usb_otg_host_frame_port_control.sv]
// Testbench: APB register and pin checks of the host port controller
// Assumes the port-side model and the bound checker
`timescale 1ns/10ps
`include "host_port_defs.vh"

module test_usb_otg_host_frame_port_control;
    logic pclk, presetn, psel, penable, pwrite, bus_dma_enable;
    logic [11:0] paddr, channel_event;
    logic [31:0] pwdata, q;
    logic [63:0] queue_entries;
    logic [3:0] queue_used;
    logic [15:0] fifo_used;
    wire [31:0] prdata;
    wire pready, pslverr, connect, grant, err_dis, ovc, resume, tmode;
    wire power, sof, illegal, port_int, chan_int;
    wire [1:0] speed, opmode, dma;
    wire [3:0] pattern;
    wire [6:0] entries;
    int errors, check_count, gap, i;

    host_port_ctrl i_host_port_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_dma_enable(bus_dma_enable),
        .device_connect(connect), .port_enable_grant(grant),
        .port_error_disable(err_dis), .overcurrent_in(ovc),
        .device_speed(speed), .resume_end(resume),
        .channel_event(channel_event), .queue_entries(queue_entries),
        .queue_used(queue_used), .fifo_used(fifo_used),
        .phy_opmode(opmode), .test_pattern(pattern), .test_mode(tmode),
        .port_power(power), .sof_pulse(sof), .dma_mode(dma),
        .dma_mode_illegal(illegal), .list_entries(entries),
        .port_interrupt_status(port_int), .host_channel_interrupt(chan_int));
    usb_device_model i_usb_device_model (.pclk(pclk), .device_connect(connect),
        .port_enable_grant(grant), .port_error_disable(err_dis),
        .overcurrent_in(ovc), .device_speed(speed), .resume_end(resume));

    // ----
    // Tasks
    // ----
    task check(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; read data lands in q, then an idle edge follows
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_sof(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (sof !== 1'b1);
    endtask
    task tally_and_finish;
        if (errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        tally_and_finish;
    end

    // ----
    // Test sequence
    // ----
    initial begin
        {presetn, psel, penable, pwrite, bus_dma_enable} = 5'h0;
        {paddr, pwdata, channel_event, queue_used, fifo_used} = 76'h0;
        queue_entries = 64'h0;
        errors = 0;
        check_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_HOST_FRAME_INTERVAL, 0);
        check("interval", 32'h0000ea60, q);
        apb(1'b0, `OFS_HOST_FRAME_NUMBER, 0);
        check("frame count", 32'h3fff, q[15:0]);
        apb(1'b0, `OFS_CHANNEL_INT_MASK, 0);
        check("channel mask", 0, q);
        apb(1'b0, `OFS_HARDWARE_CONFIG_FOUR, 0);
        check("debounce", 32'h1f, q[24:20]);
        check("data width", 32'h2, q[15:14]);
        apb(1'b0, 12'h7f0, 0);
        check("unmapped", 0, q);
        check("slverr", 0, pslverr);
        apb(1'b0, `OFS_PERIODIC_TX_FIFO_SIZE, 0);
        check("fifo size", 32'h02000315, q);
        apb(1'b1, `OFS_PERIODIC_TX_FIFO_SIZE, 32'h00080315);
        apb(1'b0, `OFS_PERIODIC_TX_FIFO_SIZE, 0);
        check("fifo clamp", 32'h00100315, q);
        apb(1'b1, `OFS_HOST_FRAME_INTERVAL, 32'd100);
        apb(1'b0, `OFS_HOST_FRAME_INTERVAL, 0);
        check("early interval", 32'h0000ea60, q);
        for (i = 0; i <= 8; i += 4) begin
            queue_entries <= {56'h0, 8'h9b ^ i[7:0]};
            queue_used <= i[3:0];
            fifo_used <= i[15:0] << 6;
            apb(1'b0, `OFS_PERIODIC_QUEUE_STATUS, 0);
            check("queue", {8'h9b ^ i[7:0], 8'h8 - i[7:0],
                16'h200 - (i[15:0] << 6)}, q);
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_HOST_CONFIGURATION, i << 24);
            @(negedge pclk);
            check("list", 32'h8 << i, entries);
        end
        check("slave", 0, {illegal, dma});
        @(posedge pclk);
        bus_dma_enable <= 1'b1;
        @(negedge pclk);
        check("buffered", 1, {illegal, dma});
        @(posedge pclk);
        bus_dma_enable <= 1'b0;
        apb(1'b1, `OFS_HOST_CONFIGURATION, 32'h00800000);
        @(negedge pclk);
        check("illegal", 4, {illegal, dma});
        @(posedge pclk);
        bus_dma_enable <= 1'b1;
        apb(1'b1, `OFS_HOST_CONFIGURATION, 0);
        @(negedge pclk);
        check("scatter", 2, {illegal, dma});
        channel_event <= 12'h805;
        apb(1'b1, `OFS_CHANNEL_INT_SUMMARY, 32'hfff);
        apb(1'b0, `OFS_CHANNEL_INT_SUMMARY, 0);
        check("summary", 32'h805, q);
        check("masked", 0, chan_int);
        apb(1'b1, `OFS_CHANNEL_INT_MASK, 32'h800);
        @(negedge pclk);
        check("unmasked", 1, chan_int);
        apb(1'b1, `OFS_CHANNEL_INT_MASK, 32'h002);
        @(negedge pclk);
        check("other mask", 0, chan_int);
        for (i = 0; i < 6; i++) begin
            apb(1'b1, `OFS_PORT_CONTROL_STATUS, {i[3:0], i[0], 12'h0});
            @(negedge pclk);
            check("test", {26'h0, i[0], i != 0, i[3:0]},
                {power, tmode, pattern});
        end
        for (i = 0; i < 3; i++) begin
            i_usb_device_model.attach(i[1:0]);
            apb(1'b0, `OFS_PORT_CONTROL_STATUS, 0);
            check("speed", i, q[18:17]);
        end
        check("connect", 1, q[1]);
        check("port int", 1, port_int);
        apb(1'b1, `OFS_PORT_CONTROL_STATUS, 32'h2);
        @(negedge pclk);
        check("connect clear", 0, port_int);
        i_usb_device_model.pulse_grant;
        apb(1'b0, `OFS_PORT_CONTROL_STATUS, 0);
        check("enable", 3, q[3:2]);
        apb(1'b1, `OFS_PORT_CONTROL_STATUS, 32'h8);
        apb(1'b1, `OFS_HOST_FRAME_INTERVAL, 32'd100);
        apb(1'b1, `OFS_HOST_FRAME_INTERVAL, 32'd200);
        apb(1'b0, `OFS_HOST_FRAME_INTERVAL, 0);
        check("interval once", 32'd100, q);
        wait_sof(gap);
        apb(1'b0, `OFS_HOST_FRAME_NUMBER, 0);
        check("wrap", 0, q[15:0]);
        wait_sof(gap);
        wait_sof(gap);
        check("spacing", 100, gap);
        apb(1'b0, `OFS_HOST_FRAME_NUMBER, 0);
        check("frame step", 2, q[15:0]);
        apb(1'b1, `OFS_HOST_FRAME_INTERVAL, 32'h00010064);
        apb(1'b1, `OFS_HOST_FRAME_INTERVAL, 32'h000100c8);
        apb(1'b0, `OFS_HOST_FRAME_INTERVAL, 0);
        check("reload", 32'h000100c8, q);
        apb(1'b1, `OFS_PORT_CONTROL_STATUS, 32'h4);
        apb(1'b0, `OFS_PORT_CONTROL_STATUS, 0);
        check("disable", 2, q[3:2]);
        i_usb_device_model.set_overcurrent(1'b1);
        apb(1'b0, `OFS_PORT_CONTROL_STATUS, 0);
        check("overcurrent", 3, q[5:4]);
        apb(1'b1, `OFS_PORT_CONTROL_STATUS, 32'h28);
        apb(1'b0, `OFS_PORT_CONTROL_STATUS, 0);
        check("flags clear", 2, q[5:3]);
        check("port int off", 0, port_int);
        i_usb_device_model.pulse_grant;
        i_usb_device_model.pulse_error;
        apb(1'b0, `OFS_PORT_CONTROL_STATUS, 0);
        check("error disable", 2, q[3:2]);
        apb(1'b1, `OFS_HOST_CONFIGURATION, 32'h08800000);
        i_usb_device_model.pulse_resume;
        @(negedge pclk);
        check("opmode resume", 2, opmode);
        repeat (205) @(posedge pclk);
        check("opmode normal", 0, opmode);
        tally_and_finish;
    end
endmodule // test_usb_otg_host_frame_port_control
